// ### src/scrpc_map.vh
`ifndef SCRPC_MAP_VH
`define SCRPC_MAP_VH

// Register byte offsets
`define SCRPC_A_LOOP_CTRL   8'h00
`define SCRPC_A_LOOP_STAT   8'h04
`define SCRPC_A_PDIV        8'h08
`define SCRPC_A_PWR_MODE    8'h0C
`define SCRPC_A_PERIPH_PWR  8'h10
`define SCRPC_A_EXT_FLAG    8'h14
`define SCRPC_A_EXT_MODE    8'h18
`define SCRPC_A_EXT_POL     8'h1C
`define SCRPC_A_EXT_WAKE    8'h20
`define SCRPC_A_REMAP       8'h24
`define SCRPC_A_RST_SRC     8'h28
`define SCRPC_A_EXT_SEL     8'h2C

// Loop control fields
`define SCRPC_LC_EN         0
`define SCRPC_LC_CONN       1
`define SCRPC_LC_MUL_LSB    2
`define SCRPC_LC_MUL_MSB    6
`define SCRPC_LC_PDV_LSB    7
`define SCRPC_LC_PDV_MSB    8

// Loop status fields
`define SCRPC_LS_LOCK       2
`define SCRPC_LS_RANGE      3
`define SCRPC_LS_REF        4

// Power mode fields
`define SCRPC_PM_IDLE       0
`define SCRPC_PM_PDOWN      1

// Pin route enable field base in the pin select register
`define SCRPC_ES_EN_LSB     18

// Peripheral divider codes
`define SCRPC_PD_QUARTER    2'h0
`define SCRPC_PD_FULL       2'h1
`define SCRPC_PD_HALF       2'h2

// Reset values
`define SCRPC_RST_MUL       5'h00
`define SCRPC_RST_PDV       2'h0
`define SCRPC_RST_REMAP     1'h0
`define SCRPC_RESET_VECTOR  32'h0000_0000

// Frequency limits in kHz
`define SCRPC_REF_MIN_KHZ   10000
`define SCRPC_REF_MAX_KHZ   25000
`define SCRPC_CCO_MIN_KHZ   156000
`define SCRPC_CCO_MAX_KHZ   320000

// Timing
`define SCRPC_CLK_MHZ       200
`define SCRPC_LOCK_US       100
`define SCRPC_WAKE_CLKS     4096

`endif

// ### src/scrpc_sync.v
`default_nettype none

module scrpc_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Data
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // Two stages; only the second stage is visible outside
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule

`default_nettype wire

// ### src/scrpc_top.v
// Added by the designer: register access over APB and the address map.
`include "scrpc_map.vh"
`default_nettype none

module scrpc_top #(
    parameter        NPERIPH     = 16,
    parameter        REF_KHZ     = 12000,
    parameter [23:0] LOCK_CYCLES = `SCRPC_LOCK_US * `SCRPC_CLK_MHZ,
    parameter [15:0] WAKE_CYCLES = `SCRPC_WAKE_CLKS
) (
    // APB slave
    input  wire                pclk,
    input  wire                presetn,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [7:0]          paddr,
    input  wire [31:0]         pwdata,
    output wire [31:0]         prdata,
    output wire                pready,
    output wire                pslverr,
    // Reset sources and status
    input  wire                ext_reset_n,
    input  wire                wdt_reset_req,
    input  wire                osc_ok,
    input  wire                init_done,
    input  wire                periph_irq,
    // External interrupt pins
    input  wire [8:0]          ext_pin,
    output wire [3:0]          eint_irq,
    // Reset and boot
    output wire                sys_rst_n,
    output wire [31:0]         reset_vector,
    output wire                vec_in_sram,
    // Clock generation control
    output wire                osc_en,
    output wire                loop_pwr,
    output wire [4:0]          loop_mult,
    output wire [1:0]          loop_post_sel,
    output wire                cpu_src_loop,
    output wire                cpu_core_clock_en,
    output wire                bus_clk_en,
    output wire [NPERIPH-1:0]  periph_clk_en,
    output wire                pin_hold
);

    // Power states
    localparam [2:0] ST_RESET = 3'h0;
    localparam [2:0] ST_RUN   = 3'h1;
    localparam [2:0] ST_IDLE  = 3'h2;
    localparam [2:0] ST_PDOWN = 3'h3;
    localparam [2:0] ST_WAKE  = 3'h4;

    wire [10:0] sync_out;
    wire [8:0]  pin_s;
    wire        rst_pin_n_s;
    wire        osc_s;
    wire        chip_rst;

    reg  [2:0]  state_q;
    reg  [15:0] wake_cnt_q;
    reg         loop_en_q;
    reg         loop_conn_q;
    reg  [4:0]  mult_q;
    reg  [1:0]  pdv_q;
    reg  [23:0] lock_cnt_q;
    reg         lock_q;
    reg         cpu_src_q;
    reg         sw_blank_q;
    reg  [1:0]  pdiv_q;
    reg  [1:0]  pdiv_act_q;
    reg  [1:0]  pcnt_q;
    reg  [NPERIPH-1:0] pconp_q;
    reg  [NPERIPH-1:0] pclk_en_q;
    reg  [3:0]  eflag_q;
    reg  [3:0]  emode_q;
    reg  [3:0]  epol_q;
    reg  [3:0]  ewake_q;
    reg  [26:0] esel_q;
    reg  [3:0]  line_prev_q;
    reg         remap_q;
    reg  [1:0]  rst_src_q;
    reg  [31:0] rdata_q;
    reg         err_q;
    reg  [31:0] rd_d;
    reg         err_d;
    reg  [3:0]  line_raw;
    reg  [31:0] cco_khz;
    integer     i;

    wire setup_ph = psel & ~penable;
    wire wr_acc   = psel & penable & pwrite;
    wire wr_lc    = wr_acc & (paddr == `SCRPC_A_LOOP_CTRL);
    wire wr_pm    = wr_acc & (paddr == `SCRPC_A_PWR_MODE);
    wire wr_flag  = wr_acc & (paddr == `SCRPC_A_EXT_FLAG);
    wire wr_rsrc  = wr_acc & (paddr == `SCRPC_A_RST_SRC);

    // Pins and analog status pass two flops before any use
    scrpc_sync #(
        .W (11)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({osc_ok, ext_reset_n, ext_pin}),
        .q     (sync_out)
    );

    assign pin_s       = sync_out[8:0];
    assign rst_pin_n_s = sync_out[9];
    assign osc_s       = sync_out[10];

    assign chip_rst = ~rst_pin_n_s | wdt_reset_req;

    // Loop oscillator frequency for the programmed setting
    always @* begin
        cco_khz = REF_KHZ * ({27'h0, mult_q} + 32'h1) * (32'h2 << pdv_q);
    end

    wire ref_ok   = (REF_KHZ >= `SCRPC_REF_MIN_KHZ) && (REF_KHZ <= `SCRPC_REF_MAX_KHZ);
    wire range_ok = (cco_khz >= `SCRPC_CCO_MIN_KHZ) && (cco_khz <= `SCRPC_CCO_MAX_KHZ);

    // Power state and wake timer
    wire eint_wake = |(eflag_q & ewake_q);
    wire wake_done = osc_s && (wake_cnt_q == WAKE_CYCLES - 16'h1);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_RESET;
            wake_cnt_q <= 16'h0;
        end else if (chip_rst) begin
            // any source restarts the wake timer
            state_q    <= ST_RESET;
            wake_cnt_q <= 16'h0;
        end else begin
            case (state_q)
                ST_RESET, ST_WAKE: begin
                    // Count only once the oscillator is seen running
                    if (!osc_s) begin
                        wake_cnt_q <= 16'h0;
                    end else if (!wake_done) begin
                        wake_cnt_q <= wake_cnt_q + 16'h1;
                    end else if (state_q == ST_WAKE || init_done) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (wr_pm && pwdata[`SCRPC_PM_PDOWN]) begin
                        state_q <= ST_PDOWN;
                    end else if (wr_pm && pwdata[`SCRPC_PM_IDLE]) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (periph_irq || (|eflag_q)) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_PDOWN: begin
                    // only enabled clockless wake sources end it
                    if (eint_wake) begin
                        state_q    <= ST_WAKE;
                        wake_cnt_q <= 16'h0;
                    end
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
        end
    end

    // reset held until state leaves reset; vector fixed at zero
    assign sys_rst_n    = (state_q != ST_RESET);
    assign reset_vector = `SCRPC_RESET_VECTOR;
    // wake restarts oscillator then waits in the timer
    assign osc_en       = (state_q != ST_PDOWN);
    // outputs frozen while asleep; register state untouched
    assign pin_hold     = (state_q == ST_PDOWN);

    // Loop control; chip reset returns everything to defaults
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_en_q   <= 1'b0;
            loop_conn_q <= 1'b0;
            mult_q      <= `SCRPC_RST_MUL;
            pdv_q       <= `SCRPC_RST_PDV;
        end else if (chip_rst) begin
            // loop off and bypassed after reset
            loop_en_q   <= 1'b0;
            loop_conn_q <= 1'b0;
            mult_q      <= `SCRPC_RST_MUL;
            pdv_q       <= `SCRPC_RST_PDV;
        end else if (wr_lc) begin
            // full 1..32 range accepted, stored minus one
            loop_en_q   <= pwdata[`SCRPC_LC_EN];
            loop_conn_q <= pwdata[`SCRPC_LC_CONN];
            mult_q      <= pwdata[`SCRPC_LC_MUL_MSB:`SCRPC_LC_MUL_LSB];
            // post divider code, divide by 2 << code
            pdv_q       <= pwdata[`SCRPC_LC_PDV_MSB:`SCRPC_LC_PDV_LSB];
        end
    end

    // loop keeps power in idle, drops in power-down and in reset
    assign loop_pwr      = loop_en_q && (state_q != ST_PDOWN) && (state_q != ST_RESET);
    assign loop_mult     = mult_q;
    assign loop_post_sel = pdv_q;

    // Lock timer; a new setting or power loss restarts it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_q <= 24'h0;
            lock_q     <= 1'b0;
        end else if (!loop_pwr || !range_ok || !ref_ok || wr_lc) begin
            lock_cnt_q <= 24'h0;
            lock_q     <= 1'b0;
        // lock reported after the settling time
        end else if (lock_cnt_q == LOCK_CYCLES - 24'h1) begin
            lock_q     <= 1'b1;
        end else begin
            lock_cnt_q <= lock_cnt_q + 24'h1;
        end
    end

    // Core clock source: one blank cycle around each swap avoids runt pulses
    // loop output used only once enabled, locked and connected
    wire src_want = loop_pwr & lock_q & loop_conn_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_src_q  <= 1'b0;
            sw_blank_q <= 1'b0;
        end else if (src_want != cpu_src_q) begin
            if (!sw_blank_q) begin
                sw_blank_q <= 1'b1;
            end else begin
                cpu_src_q  <= src_want;
                sw_blank_q <= 1'b0;
            end
        end else begin
            sw_blank_q <= 1'b0;
        end
    end

    assign cpu_src_loop = cpu_src_q;
    // core and bus clocks stop in idle
    assign cpu_core_clock_en = (state_q == ST_RUN) & ~sw_blank_q;
    assign bus_clk_en        = (state_q == ST_RUN) & ~sw_blank_q;

    // Peripheral divider; new ratio applied only at a period boundary
    wire periph_live = ((state_q == ST_RUN) || (state_q == ST_IDLE)) & ~sw_blank_q;
    wire [1:0] pterm = (pdiv_act_q == `SCRPC_PD_FULL) ? 2'h0 :
                       (pdiv_act_q == `SCRPC_PD_HALF) ? 2'h1 : 2'h3;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt_q     <= 2'h0;
            pdiv_act_q <= `SCRPC_PD_QUARTER;
            pclk_en_q  <= {NPERIPH{1'b0}};
        end else begin
            if (periph_live && pcnt_q >= pterm) begin
                pcnt_q     <= 2'h0;
                // ratio change lands on a whole period
                pdiv_act_q <= pdiv_q;
            end else if (periph_live) begin
                pcnt_q     <= pcnt_q + 2'h1;
            end
            pclk_en_q <= (periph_live && pcnt_q >= pterm) ? pconp_q : {NPERIPH{1'b0}};
        end
    end

    assign periph_clk_en = pclk_en_q;

    // External lines: route enabled pins, apply polarity
    // nine pins merged into four lines
    always @* begin
        line_raw = 4'h0;
        for (i = 0; i < 9; i = i + 1) begin
            if (esel_q[`SCRPC_ES_EN_LSB + i]) begin
                line_raw[esel_q[2*i +: 2]] = line_raw[esel_q[2*i +: 2]]
                    | (pin_s[i] ~^ epol_q[esel_q[2*i +: 2]]);
            end
        end
    end

    // Sticky flags; set wins over a write-one clear
    wire [3:0] eset = (emode_q & line_raw & ~line_prev_q) | (~emode_q & line_raw);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eflag_q     <= 4'h0;
            line_prev_q <= 4'h0;
        end else begin
            line_prev_q <= line_raw;
            eflag_q     <= (eflag_q & ~(wr_flag ? pwdata[3:0] : 4'h0)) | eset;
        end
    end

    assign eint_irq = eflag_q;

    // Reset cause, cleared by write-one, only presetn wipes it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_src_q <= 2'h0;
        end else begin
            rst_src_q <= (rst_src_q & ~(wr_rsrc ? pwdata[1:0] : 2'h0))
                       | {wdt_reset_req, ~rst_pin_n_s};
        end
    end

    // Plain configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pdiv_q  <= `SCRPC_PD_QUARTER;
            pconp_q <= {NPERIPH{1'b1}};
            emode_q <= 4'h0;
            epol_q  <= 4'h0;
            ewake_q <= 4'h0;
            esel_q  <= 27'h0;
            remap_q <= `SCRPC_RST_REMAP;
        end else if (chip_rst) begin
            pdiv_q  <= `SCRPC_PD_QUARTER;
            pconp_q <= {NPERIPH{1'b1}};
            emode_q <= 4'h0;
            epol_q  <= 4'h0;
            ewake_q <= 4'h0;
            esel_q  <= 27'h0;
            remap_q <= `SCRPC_RST_REMAP;
        end else if (wr_acc) begin
            case (paddr)
                `SCRPC_A_PDIV:       pdiv_q  <= pwdata[1:0];
                `SCRPC_A_PERIPH_PWR: pconp_q <= pwdata[NPERIPH-1:0];
                `SCRPC_A_EXT_MODE:   emode_q <= pwdata[3:0];
                `SCRPC_A_EXT_POL:    epol_q  <= pwdata[3:0];
                `SCRPC_A_EXT_WAKE:   ewake_q <= pwdata[3:0];
                `SCRPC_A_EXT_SEL:    esel_q  <= pwdata[26:0];
                `SCRPC_A_REMAP:      remap_q <= pwdata[0];
                default: begin
                end
            endcase
        end
    end

    assign vec_in_sram = remap_q;

    // Read mux and unmapped-address decode
    always @* begin
        rd_d  = 32'h0;
        err_d = 1'b0;
        case (paddr)
            `SCRPC_A_LOOP_CTRL: rd_d = {23'h0, pdv_q, mult_q, loop_conn_q, loop_en_q};
            `SCRPC_A_LOOP_STAT: rd_d = {27'h0, ref_ok, range_ok, lock_q, cpu_src_q, loop_pwr};
            `SCRPC_A_PDIV:       rd_d = {30'h0, pdiv_q};
            `SCRPC_A_PWR_MODE:   rd_d = 32'h0;
            `SCRPC_A_PERIPH_PWR: rd_d = {{(32-NPERIPH){1'b0}}, pconp_q};
            `SCRPC_A_EXT_FLAG:   rd_d = {28'h0, eflag_q};
            `SCRPC_A_EXT_MODE:   rd_d = {28'h0, emode_q};
            `SCRPC_A_EXT_POL:    rd_d = {28'h0, epol_q};
            `SCRPC_A_EXT_WAKE:   rd_d = {28'h0, ewake_q};
            `SCRPC_A_REMAP:      rd_d = {31'h0, remap_q};
            `SCRPC_A_RST_SRC:    rd_d = {30'h0, rst_src_q};
            `SCRPC_A_EXT_SEL:    rd_d = {5'h0, esel_q};
            default:             err_d = 1'b1;
        endcase
    end

    // Read data and error captured in setup; access completes at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0;
            err_q   <= 1'b0;
        end else if (setup_ph) begin
            rdata_q <= pwrite ? 32'h0 : rd_d;
            err_q   <= err_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & err_q;

endmodule

`default_nettype wire

// ### tb/scrpc_chk_asserts.sv
`default_nettype none
module scrpc_chk #(
    parameter NPERIPH = 16
) (
    // Clock, reset and bus
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    // Reset sources and status
    input wire logic               ext_reset_n,
    input wire logic               wdt_reset_req,
    input wire logic               osc_ok,
    input wire logic               init_done,
    // Block outputs
    input wire logic [3:0]         eint_irq,
    input wire logic               sys_rst_n,
    input wire logic [31:0]        reset_vector,
    input wire logic               osc_en,
    input wire logic               loop_pwr,
    input wire logic               cpu_src_loop,
    input wire logic               cpu_core_clock_en,
    input wire logic               bus_clk_en,
    input wire logic [NPERIPH-1:0] periph_clk_en,
    input wire logic               pin_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Power-down exit
    sequence s_wake;
        $fell(pin_hold);
    endsequence
    // Pin low long enough to pass sync
    sequence s_pin_rst;
        !ext_reset_n [*2];
    endsequence
    a_vector_zero: assert property (reset_vector == 32'h0000_0000)
        else $error("reset vector not zero");
    a_loop_off: assert property ($rose(sys_rst_n) |-> !loop_pwr && !cpu_src_loop)
        else $error("loop active when reset ends");
    a_wdt_reset: assert property (wdt_reset_req |-> ##[1:3] !sys_rst_n)
        else $error("watchdog request gave no reset");
    a_pin_reset: assert property (s_pin_rst |-> ##[0:4] !sys_rst_n)
        else $error("reset pin gave no reset");
    // Sync plus wake count follow
    a_wait_osc: assert property (!sys_rst_n && !osc_ok |=> !sys_rst_n [*8])
        else $error("reset released before oscillator settled");
    a_wait_init: assert property (!sys_rst_n && !init_done |=> !sys_rst_n)
        else $error("reset released before init finished");
    // Swap only after a core stall
    a_swap_blank: assert property (
        $rose(cpu_src_loop) |-> loop_pwr && $past(!cpu_core_clock_en))
        else $error("core source switched without stall");
    a_pdown_stop: assert property (
        pin_hold |-> !osc_en && !cpu_core_clock_en && !bus_clk_en)
        else $error("clock running in power-down");
    // Ticks registered: skip entry cycle
    a_pdown_ticks: assert property (
        pin_hold [*2] |-> !loop_pwr && periph_clk_en == '0)
        else $error("loop or peripheral tick in power-down");
    a_wake_timer: assert property (s_wake |-> !cpu_core_clock_en [*8])
        else $error("core resumed without wake timer");
    a_wake_cause: assert property (s_wake |-> eint_irq != 4'h0 || !sys_rst_n)
        else $error("power-down left without cause");
    a_flag_sticky: assert property ($fell(eint_irq[2]) |-> !sys_rst_n ||
        $past(psel && penable && pwrite && paddr == 8'h14 && pwdata[2]))
        else $error("line flag dropped without clear");
endmodule

bind scrpc_top scrpc_chk #(.NPERIPH(NPERIPH)) chk_u (.*);
`default_nettype wire

// ### tb/scrpc_osc_model.sv
`default_nettype none
module scrpc_osc_model #(
    parameter OSC_DLY  = 10,
    parameter INIT_DLY = 30
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Block controls
    input  wire logic osc_en,
    input  wire logic sys_rst_n,
    // Status back to the block
    output wire logic osc_ok,
    output wire logic init_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int   osc_cnt_q;
    int   init_cnt_q;
    logic rst_seen_q;
    assign osc_ok = osc_en && osc_cnt_q >= OSC_DLY;
    // Amplitude builds up only while enabled, never instantly
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || !osc_en) begin
            osc_cnt_q <= 0;
        end else if (osc_cnt_q < OSC_DLY) begin
            osc_cnt_q <= osc_cnt_q + 1;
        end
    end
    assign init_done = init_cnt_q >= INIT_DLY;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_q <= 0;
            rst_seen_q <= 1'b0;
        end else begin
            rst_seen_q <= sys_rst_n;
            if (rst_seen_q && !sys_rst_n) begin
                init_cnt_q <= 0;
            end else if (init_cnt_q < INIT_DLY) begin
                init_cnt_q <= init_cnt_q + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`include "scrpc_map.vh"
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c) n = 0; while (!(c)) begin @(negedge pclk); n++; end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Stimulus
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        ext_reset_n = 1'b1;
    logic        wdt_reset_req = 1'b0;
    logic        periph_irq = 1'b0;
    logic [8:0]  ext_pin = 9'h000;
    // Outputs
    wire logic [31:0] prdata, reset_vector;
    wire logic [15:0] periph_clk_en;
    wire logic [4:0]  loop_mult;
    wire logic [3:0]  eint_irq;
    wire logic [1:0]  loop_post_sel;
    wire logic        pready, pslverr, osc_ok, init_done, sys_rst_n, vec_in_sram;
    wire logic        osc_en, loop_pwr, cpu_src_loop, cpu_core_clock_en, bus_clk_en, pin_hold;
    // Bookkeeping
    logic [31:0] rd;
    logic        err;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cyc_cnt = 0;

    // Short lock and wake counts keep the run brief
    scrpc_top #(.LOCK_CYCLES(24'h000014), .WAKE_CYCLES(16'h0008)) dut_u (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_reset_n,
        .wdt_reset_req, .osc_ok, .init_done, .periph_irq, .ext_pin, .eint_irq, .sys_rst_n,
        .reset_vector, .vec_in_sram, .osc_en, .loop_pwr, .loop_mult, .loop_post_sel,
        .cpu_src_loop, .cpu_core_clock_en, .bus_clk_en, .periph_clk_en, .pin_hold);
    scrpc_osc_model osc_u (.pclk, .presetn, .osc_en, .sys_rst_n, .osc_ok, .init_done);

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    // One transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset;
        int n;
        repeat (20) @(negedge pclk);
        `CHK("rst_hold", 1'b0, sys_rst_n)
        `WAITC(sys_rst_n)
        `CHK("rst_end", 1'b1, sys_rst_n)
        `CHK("vector", 32'h0000_0000, reset_vector)
        `CHK("remap", 1'b0, vec_in_sram)
        `CHK("loop_pwr", 1'b0, loop_pwr)
        `CHK("src", 1'b0, cpu_src_loop)
        apb(1'b0, `SCRPC_A_PDIV, 32'h0000_0000);
        `CHK("pdiv", 32'h0000_0000, rd)
        apb(1'b0, `SCRPC_A_PERIPH_PWR, 32'h0000_0000);
        `CHK("pwr_mask", 32'h0000_FFFF, rd)
        $display("test reset done");
    endtask

    task automatic t_pdiv;
        logic [1:0] code [3] = '{`SCRPC_PD_FULL, `SCRPC_PD_HALF, `SCRPC_PD_QUARTER};
        int         exp [3] = '{40, 20, 10};
        int         c0;
        int         c1;
        apb(1'b1, `SCRPC_A_PERIPH_PWR, 32'h0000_FFFE);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `SCRPC_A_PDIV, {30'h0000_0000, code[i]});
            repeat (8) @(negedge pclk);
            c0 = 0;
            c1 = 0;
            repeat (40) begin
                @(negedge pclk);
                c0 += periph_clk_en[0];
                c1 += periph_clk_en[1];
            end
            `CHK("tick_off", 0, c0)
            `CHK("tick_rate", exp[i], c1)
        end
        apb(1'b1, `SCRPC_A_PERIPH_PWR, 32'h0000_FFFF);
        $display("test pdiv done");
    endtask

    task automatic t_loop;
        logic [31:0] bad_set [2] = '{32'h0000_0001, 32'h0000_01FD};
        int          n;
        foreach (bad_set[i]) begin
            apb(1'b1, `SCRPC_A_LOOP_CTRL, bad_set[i]);
            repeat (40) @(negedge pclk);
            `CHK("mult", bad_set[i][6:2], loop_mult)
            `CHK("post", bad_set[i][8:7], loop_post_sel)
            apb(1'b1, `SCRPC_A_LOOP_CTRL, bad_set[i] | 32'h0000_0002);
            apb(1'b0, `SCRPC_A_LOOP_STAT, 32'h0000_0000);
            `CHK("lock_bad", 1'b0, rd[2])
            `CHK("no_conn", 1'b0, cpu_src_loop)
        end
        apb(1'b1, `SCRPC_A_LOOP_CTRL, 32'h0000_0095);
        repeat (5) @(negedge pclk);
        apb(1'b0, `SCRPC_A_LOOP_STAT, 32'h0000_0000);
        `CHK("lock_early", 1'b0, rd[2])
        repeat (20) @(negedge pclk);
        apb(1'b0, `SCRPC_A_LOOP_STAT, 32'h0000_0000);
        `CHK("lock", 3'h7, rd[4:2])
        apb(1'b1, `SCRPC_A_LOOP_CTRL, 32'h0000_0097);
        `WAITC(cpu_src_loop)
        repeat (2) @(negedge pclk);
        `CHK("conn", 2'h3, {cpu_src_loop, cpu_core_clock_en})
        $display("test loop done");
    endtask

    task automatic t_idle;
        int n;
        int c;
        apb(1'b1, `SCRPC_A_PWR_MODE, 32'h0000_0001);
        repeat (2) @(negedge pclk);
        c = 0;
        repeat (8) begin
            @(negedge pclk);
            c += periph_clk_en[1];
        end
        `CHK("idle_core", 2'h0, {cpu_core_clock_en, bus_clk_en})
        `CHK("idle_ticks", 2, c)
        `CHK("idle_loop", 1'b1, loop_pwr)
        @(posedge pclk);
        periph_irq <= 1'b1;
        `WAITC(cpu_core_clock_en)
        `CHK("resume", 1'b1, cpu_core_clock_en)
        @(posedge pclk);
        periph_irq <= 1'b0;
        $display("test idle done");
    endtask

    task automatic t_pdown;
        int n;
        apb(1'b1, `SCRPC_A_EXT_MODE, 32'h0000_0004);
        apb(1'b1, `SCRPC_A_EXT_POL, 32'h0000_0004);
        apb(1'b1, `SCRPC_A_EXT_SEL, 32'h0020_0080);
        apb(1'b1, `SCRPC_A_EXT_WAKE, 32'h0000_0004);
        apb(1'b1, `SCRPC_A_PWR_MODE, 32'h0000_0002);
        repeat (12) @(negedge pclk);
        `CHK("pd_osc", 2'h0, {osc_en, cpu_core_clock_en})
        `CHK("pd_ticks", 16'h0000, periph_clk_en)
        `CHK("pd_hold", 1'b1, pin_hold)
        @(posedge pclk);
        ext_pin[3] <= 1'b1;
        `WAITC(cpu_core_clock_en)
        `CHK("wake_len", 1'b1, n > 17)
        `CHK("eint", 4'h4, eint_irq)
        apb(1'b1, `SCRPC_A_EXT_FLAG, 32'h0000_0004);
        apb(1'b0, `SCRPC_A_EXT_FLAG, 32'h0000_0000);
        `CHK("flag_clr", 32'h0000_0000, rd)
        @(posedge pclk);
        ext_pin[3] <= 1'b0;
        $display("test pdown done");
    endtask

    task automatic t_rst_src;
        int n;
        apb(1'b1, `SCRPC_A_REMAP, 32'h0000_0001);
        @(negedge pclk);
        `CHK("remap_on", 1'b1, vec_in_sram)
        apb(1'b0, 8'h30, 32'h0000_0000);
        `CHK("unmapped", 33'h0_0000_0001, {rd, err})
        @(posedge pclk);
        wdt_reset_req <= 1'b1;
        @(posedge pclk);
        wdt_reset_req <= 1'b0;
        `WAITC(!sys_rst_n)
        `CHK("wdt_rst", 1'b0, sys_rst_n)
        `WAITC(sys_rst_n)
        `CHK("defaults", 2'h0, {vec_in_sram, loop_pwr})
        @(posedge pclk);
        ext_reset_n <= 1'b0;
        repeat (6) @(posedge pclk);
        ext_reset_n <= 1'b1;
        `CHK("pin_rst", 1'b0, sys_rst_n)
        `WAITC(sys_rst_n)
        apb(1'b0, `SCRPC_A_RST_SRC, 32'h0000_0000);
        `CHK("rst_src", 32'h0000_0003, rd)
        $display("test reset source done");
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard, over twice the expected run
    always @(posedge pclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            bad_count++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pdiv();
        t_loop();
        t_idle();
        t_pdown();
        t_rst_src();
        final_report();
    end
endmodule
`default_nettype wire
